// ---- spmc_consts.vh ----
// Constants for the switch power mode controller: register indices,
// field positions, reset values, mode codes and timing figures.
// Assumes a 50 MHz system clock; included by bare name.
`ifndef SPMC_CONSTS_VH
`define SPMC_CONSTS_VH

// ************************************************************
// Register indices (byte address = 4 * index)
// ************************************************************
`define SPMC_IDX_P1_CTRL 8'h1d
`define SPMC_IDX_P2_CTRL 8'h2d
`define SPMC_IDX_GLOBAL 8'hc3
`define SPMC_IDX_TIMEOUT 8'hc4
`define SPMC_IDX_STATUS 8'hf0

// ************************************************************
// Fields and reset values
// ************************************************************
`define SPMC_PORT_PD_BIT 3
`define SPMC_PLL_OFF_BIT 2
`define SPMC_PORT_RST 8'h00
`define SPMC_GLOBAL_RST 8'h00
`define SPMC_TIMEOUT_RST 8'h80

// ************************************************************
// Global power field codes
// ************************************************************
`define SPMC_MODE_NORMAL 2'h0
`define SPMC_MODE_ENERGY 2'h1
`define SPMC_MODE_SOFTPD 2'h2
`define SPMC_MODE_SAVING 2'h3

// ************************************************************
// Timing
// ************************************************************
`define SPMC_CLK_NS 20
`define SPMC_PULSE_NS 120
`define SPMC_PULSE_CYC ((`SPMC_PULSE_NS + `SPMC_CLK_NS - 1) / `SPMC_CLK_NS)
`define SPMC_PULSE_PERIOD_NS 1000000000
`define SPMC_PULSE_PERIOD_CYC (`SPMC_PULSE_PERIOD_NS / `SPMC_CLK_NS)
`define SPMC_SLEEP_UNIT_NS 1000000
`define SPMC_SLEEP_UNIT_CYC (`SPMC_SLEEP_UNIT_NS / `SPMC_CLK_NS)

`endif

// ---- spmc_tick.v ----
// Free divider that gives a one-cycle enable pulse every DIV cycles.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/10ps
module spmc_tick #(
    parameter W = 32,
    parameter DIV = 50000
) (
    input wire clk_i,        // System clock
    input wire rst_i,        // Synchronous reset
    input wire run_i,        // Count while high, restart when low
    output reg tick_o        // One-cycle enable pulse
);
    reg [W-1:0] cnt_q;

    always @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            cnt_q <= {W{1'b0}};
            tick_o <= 1'b0;
        end else if (cnt_q == DIV[W-1:0] - {{(W-1){1'b0}}, 1'b1}) begin
            cnt_q <= {W{1'b0}};
            tick_o <= 1'b1;
        end else begin
            cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
            tick_o <= 1'b0;
        end
    end
endmodule

// ---- spmc_pulse.v ----
// Stretches a one-cycle trigger into a pulse of LEN cycles.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/10ps
module spmc_pulse #(
    parameter W = 8,
    parameter LEN = 6
) (
    input wire clk_i,        // System clock
    input wire rst_i,        // Synchronous reset
    input wire trig_i,       // Start pulse
    input wire kill_i,       // Abort pulse at once
    output wire pulse_o      // Stretched pulse
);
    reg [W-1:0] left_q;

    always @(posedge clk_i) begin
        if (rst_i || kill_i)
            left_q <= {W{1'b0}};
        else if (trig_i)
            left_q <= LEN[W-1:0];
        else if (left_q != {W{1'b0}})
            left_q <= left_q - {{(W-1){1'b0}}, 1'b1};
    end

    assign pulse_o = (left_q != {W{1'b0}});
endmodule

// ---- spmc_top.v ----
// Power mode controller for a three-port switch with two copper PHYs,
// with a classic Wishbone register slave.
// Assumes all inputs synchronous to CLK_I; line status comes from the PHYs.
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/10ps
`include "spmc_consts.vh"
module spmc_top #(
    parameter PULSE_PERIOD_CYC = `SPMC_PULSE_PERIOD_CYC,
    parameter SLEEP_UNIT_CYC = `SPMC_SLEEP_UNIT_CYC
) (
    input wire CLK_I,              // System clock, 50 MHz
    input wire RST_I,              // Synchronous reset, active high
    input wire CYC_I,              // Wishbone cycle
    input wire STB_I,              // Wishbone strobe
    input wire WE_I,               // Wishbone write enable
    input wire [9:0] ADR_I,        // Wishbone byte address
    input wire [3:0] SEL_I,        // Wishbone byte selects
    input wire [31:0] DAT_I,       // Wishbone write data
    output reg [31:0] DAT_O,       // Wishbone read data
    output reg ACK_O,              // Wishbone acknowledge
    input wire [1:0] AN_EN_I,      // Auto-negotiation enabled per port
    input wire [1:0] LINK_I,       // Link up per port
    input wire [1:0] ENERGY_I,     // Line energy seen per port
    input wire [1:0] MGMT_PD_WR_I, // PHY management write of power-down
    input wire [1:0] MGMT_PD_I,    // PHY management power-down value
    output reg PLL_EN_O,           // Internal PLL clock enable
    output reg MAC_EN_O,           // MAC enable
    output reg HOST_IF_EN_O,       // Host interface enable
    output reg [1:0] PHY_TX_EN_O,  // PHY transmitter enable
    output reg [1:0] PHY_RX_EN_O,  // PHY full receiver enable
    output reg [1:0] PHY_ED_EN_O,  // PHY energy detector enable
    output reg [1:0] LINK_PULSE_O  // Energy detect line pulse
);
    // ************************************************************
    // Register file
    // ************************************************************
    reg [7:0] p1_ctrl_q;
    reg [7:0] p2_ctrl_q;
    reg [7:0] global_q;
    reg [7:0] timeout_q;
    wire [7:0] idx = ADR_I[9:2];
    wire req = CYC_I & STB_I;
    // Writes land on the edge where the master samples ACK high
    wire wr_now = req & WE_I & ACK_O & SEL_I[0];
    wire [1:0] mode = global_q[1:0];
    wire [1:0] port_pd = {p2_ctrl_q[`SPMC_PORT_PD_BIT], p1_ctrl_q[`SPMC_PORT_PD_BIT]};
    wire [7:0] status;

    always @(posedge CLK_I) begin
        if (RST_I) begin
            p1_ctrl_q <= `SPMC_PORT_RST;
            p2_ctrl_q <= `SPMC_PORT_RST;
            global_q <= `SPMC_GLOBAL_RST;
            timeout_q <= `SPMC_TIMEOUT_RST;
        end else begin
            // Management path first so a bus write of the same cycle wins
            if (MGMT_PD_WR_I[0])
                p1_ctrl_q[`SPMC_PORT_PD_BIT] <= MGMT_PD_I[0];
            if (MGMT_PD_WR_I[1])
                p2_ctrl_q[`SPMC_PORT_PD_BIT] <= MGMT_PD_I[1];
            if (wr_now) begin
                case (idx)
                    `SPMC_IDX_P1_CTRL: p1_ctrl_q <= DAT_I[7:0];
                    `SPMC_IDX_P2_CTRL: p2_ctrl_q <= DAT_I[7:0];
                    `SPMC_IDX_GLOBAL: global_q <= DAT_I[7:0];
                    `SPMC_IDX_TIMEOUT: timeout_q <= DAT_I[7:0];
                    default: ;
                endcase
            end
        end
    end

    // ************************************************************
    // Wishbone answer
    // ************************************************************
    // One wait state: ACK the cycle after the request, drop it the next.
    // Unmapped indices are acknowledged with zero data and no effect.
    always @(posedge CLK_I) begin
        if (RST_I) begin
            ACK_O <= 1'b0;
            DAT_O <= 32'h0;
        end else begin
            ACK_O <= req & ~ACK_O;
            if (req & ~ACK_O & ~WE_I) begin
                case (idx)
                    `SPMC_IDX_P1_CTRL: DAT_O <= {24'h0, p1_ctrl_q};
                    `SPMC_IDX_P2_CTRL: DAT_O <= {24'h0, p2_ctrl_q};
                    `SPMC_IDX_GLOBAL: DAT_O <= {24'h0, global_q};
                    `SPMC_IDX_TIMEOUT: DAT_O <= {24'h0, timeout_q};
                    `SPMC_IDX_STATUS: DAT_O <= {24'h0, status};
                    default: DAT_O <= 32'h0;
                endcase
            end else begin
                DAT_O <= 32'h0;
            end
        end
    end

    // ************************************************************
    // Mode decode
    // ************************************************************
    wire m_norm = (mode == `SPMC_MODE_NORMAL);
    wire m_ed = (mode == `SPMC_MODE_ENERGY);
    wire m_spd = (mode == `SPMC_MODE_SOFTPD);
    wire m_ps = (mode == `SPMC_MODE_SAVING);
    wire pll_off = global_q[`SPMC_PLL_OFF_BIT];

    // ************************************************************
    // Time bases
    // ************************************************************
    wire unit_tick;
    wire sec_tick;

    spmc_tick #(.W(32), .DIV(SLEEP_UNIT_CYC)) u_unit (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .run_i(m_ed),
        .tick_o(unit_tick)
    );

    spmc_tick #(.W(32), .DIV(PULSE_PERIOD_CYC)) u_sec (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .run_i(m_ed),
        .tick_o(sec_tick)
    );

    // ************************************************************
    // Energy detect sleep state
    // ************************************************************
    // Powered-down ports are ignored so a dead port cannot hold the
    // device awake, and cannot wake it either.
    wire [1:0] live = ~port_pd;
    wire any_energy = |((ENERGY_I | LINK_I) & live);
    reg [8:0] idle_q;
    reg ed_low_q;

    always @(posedge CLK_I) begin
        if (RST_I || !m_ed || any_energy) begin
            idle_q <= 9'h0;
            ed_low_q <= 1'b0;
        end else if (unit_tick) begin
            if (idle_q > {1'b0, timeout_q})
                ed_low_q <= 1'b1;
            else
                idle_q <= idle_q + 9'h1;
        end
    end

    // ************************************************************
    // Per-port saving state and line pulses
    // ************************************************************
    wire [1:0] ps_sleep;
    wire [1:0] pulse;
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_port
            reg ps_q;
            // Cable unplugged means no energy and no link on the pair
            always @(posedge CLK_I) begin
                if (RST_I)
                    ps_q <= 1'b0;
                else
                    ps_q <= m_ps & AN_EN_I[g] & ~ENERGY_I[g] & ~LINK_I[g];
            end
            assign ps_sleep[g] = ps_q;

            spmc_pulse #(.W(8), .LEN(`SPMC_PULSE_CYC)) u_pulse (
                .clk_i(CLK_I),
                .rst_i(RST_I),
                .trig_i(sec_tick & ~LINK_I[g] & live[g]),
                .kill_i(~m_ed | port_pd[g]),
                .pulse_o(pulse[g])
            );
        end
    endgenerate

    // ************************************************************
    // Block enables
    // ************************************************************
    reg pll_d;
    reg mac_d;
    reg host_d;
    reg [1:0] tx_d;
    reg [1:0] rx_d;
    reg [1:0] ed_d;

    always @* begin
        pll_d = 1'b1;
        mac_d = 1'b1;
        host_d = 1'b1;
        tx_d = 2'b11;
        rx_d = 2'b11;
        ed_d = 2'b11;
        case (mode)
            `SPMC_MODE_NORMAL: begin
                pll_d = 1'b1;
            end
            `SPMC_MODE_SAVING: begin
                rx_d = ~ps_sleep;
            end
            `SPMC_MODE_ENERGY: begin
                if (ed_low_q) begin
                    pll_d = 1'b0;
                    mac_d = 1'b0;
                    host_d = 1'b0;
                    tx_d = 2'b00;
                    rx_d = 2'b00;
                end
            end
            `SPMC_MODE_SOFTPD: begin
                pll_d = 1'b0;
                mac_d = 1'b0;
                host_d = 1'b0;
                tx_d = 2'b00;
                rx_d = 2'b00;
                ed_d = 2'b00;
            end
            default: begin
                pll_d = 1'b1;
            end
        endcase
        if (pll_off)
            pll_d = 1'b0;
        // Port power-down overrides whatever the global mode asks for
        tx_d = tx_d & live;
        rx_d = rx_d & live;
        ed_d = ed_d & live;
    end

    always @(posedge CLK_I) begin
        if (RST_I) begin
            PLL_EN_O <= 1'b1;
            MAC_EN_O <= 1'b1;
            HOST_IF_EN_O <= 1'b1;
            PHY_TX_EN_O <= 2'b11;
            PHY_RX_EN_O <= 2'b11;
            PHY_ED_EN_O <= 2'b11;
            LINK_PULSE_O <= 2'b00;
        end else begin
            PLL_EN_O <= pll_d;
            MAC_EN_O <= mac_d;
            HOST_IF_EN_O <= host_d;
            PHY_TX_EN_O <= tx_d;
            PHY_RX_EN_O <= rx_d;
            PHY_ED_EN_O <= ed_d;
            // A port powered down in mid-pulse goes quiet on the same edge as its PHY
            LINK_PULSE_O <= pulse & live;
        end
    end

    // ************************************************************
    // Status view
    // ************************************************************
    // Register contents are never touched by a mode change, so software
    // reads back exactly what it wrote after leaving any low power mode.
    assign status = {PHY_RX_EN_O, PLL_EN_O, ps_sleep, ed_low_q, m_spd | m_ed, m_norm};
endmodule

// ---- spmc_checker.sv ----
// Port-level checker for the switch power mode controller.
// Assumes it is bound into spmc_top; one clock, synchronous reset.
`timescale 1ns/10ps
module spmc_checker #(
    parameter PULSE_PERIOD_CYC = 40, // pulse spacing
    parameter SLEEP_UNIT_CYC = 4 // idle tick
) (
    input wire CLK_I, // clock
    input wire RST_I, // reset
    input wire CYC_I, // cycle
    input wire STB_I, // strobe
    input wire WE_I, // write
    input wire [9:0] ADR_I, // address
    input wire [3:0] SEL_I, // selects
    input wire [31:0] DAT_I, // write data
    input wire ACK_O, // ack
    input wire [1:0] AN_EN_I, // autoneg
    input wire [1:0] LINK_I, // link
    input wire [1:0] ENERGY_I, // energy
    input wire [1:0] MGMT_PD_WR_I, // mgmt strobe
    input wire [1:0] MGMT_PD_I, // mgmt value
    input wire PLL_EN_O, // pll
    input wire MAC_EN_O, // mac
    input wire HOST_IF_EN_O, // host
    input wire [1:0] PHY_TX_EN_O, // tx
    input wire [1:0] PHY_RX_EN_O, // rx
    input wire [1:0] PHY_ED_EN_O, // detector
    input wire [1:0] LINK_PULSE_O // pulses
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    // ********
    // Shadow of the mode and port 1 power-down, taken at the ack edge
    // ********
    reg [7:0] g_q;
    reg pd1_q;
    wire wr = CYC_I && STB_I && WE_I && ACK_O && SEL_I[0];
    wire sleep0 = g_q[1:0] == 2'h3 && AN_EN_I[0] && !ENERGY_I[0] && !LINK_I[0] && !pd1_q;
    wire wake0 = g_q[0] && ENERGY_I[0] && !pd1_q;
    always @(posedge CLK_I) begin
        if (RST_I) begin
            g_q <= 8'h00;
            pd1_q <= 1'b0;
        end else begin
            if (wr && ADR_I[9:2] == 8'hc3) g_q <= DAT_I[7:0];
            // Bus write wins over a management write in the same cycle
            if (wr && ADR_I[9:2] == 8'h1d) pd1_q <= DAT_I[3];
            else if (MGMT_PD_WR_I[0]) pd1_q <= MGMT_PD_I[0];
        end
    end
    sequence s_sleep; sleep0 [*3]; endsequence
    sequence s_wake; wake0 [*3]; endsequence
    sequence s_pulse; LINK_PULSE_O[0] [*6] ##1 !LINK_PULSE_O[0]; endsequence
    a_ack_single: assert property (ACK_O |=> !ACK_O)
    else $error("ack longer than a cycle");
    a_ack_answer: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("request not acked");
    a_normal_on: assert property (g_q[2:0] == 3'h0 && $stable(g_q)
        |-> PLL_EN_O && MAC_EN_O && HOST_IF_EN_O)
    else $error("normal mode not fully on");
    a_softpd_off: assert property (g_q[1:0] == 2'h2 && $stable(g_q) |-> {PLL_EN_O, MAC_EN_O,
        HOST_IF_EN_O, PHY_TX_EN_O, PHY_RX_EN_O, PHY_ED_EN_O} == 9'h000)
    else $error("soft power down left a block on");
    a_pll_off: assert property (g_q[2] && $stable(g_q) |-> !PLL_EN_O)
    else $error("pll on with disable bit set");
    a_ed_low: assert property (g_q[1:0] == 2'h1 && !MAC_EN_O
        |-> !PLL_EN_O && !HOST_IF_EN_O && PHY_RX_EN_O == 2'b00)
    else $error("low power state left a block on");
    a_saving_rx: assert property (s_sleep |-> !PHY_RX_EN_O[0] && PHY_TX_EN_O[0]
        && PHY_ED_EN_O[0] && MAC_EN_O)
    else $error("saving port 1 enables wrong");
    a_port_wake: assert property (s_wake |-> PHY_RX_EN_O[0] && MAC_EN_O)
    else $error("energy did not wake port 1");
    a_port_off: assert property (pd1_q && $past(pd1_q) |-> !PHY_TX_EN_O[0] && !PHY_RX_EN_O[0]
        && !PHY_ED_EN_O[0] && !LINK_PULSE_O[0])
    else $error("powered down port 1 active");
    a_pulse_len: assert property (disable iff (RST_I || g_q[1:0] != 2'h1 || pd1_q)
        $rose(LINK_PULSE_O[0]) |-> g_q[1:0] == 2'h1 ##0 s_pulse)
    else $error("line pulse width wrong");
endmodule
bind spmc_top spmc_checker #(.PULSE_PERIOD_CYC(PULSE_PERIOD_CYC),
    .SLEEP_UNIT_CYC(SLEEP_UNIT_CYC)) u_chk (
    .CLK_I(CLK_I),
    .RST_I(RST_I),
    .CYC_I(CYC_I),
    .STB_I(STB_I),
    .WE_I(WE_I),
    .ADR_I(ADR_I),
    .SEL_I(SEL_I),
    .DAT_I(DAT_I),
    .ACK_O(ACK_O),
    .AN_EN_I(AN_EN_I),
    .LINK_I(LINK_I),
    .ENERGY_I(ENERGY_I),
    .MGMT_PD_WR_I(MGMT_PD_WR_I),
    .MGMT_PD_I(MGMT_PD_I),
    .PLL_EN_O(PLL_EN_O),
    .MAC_EN_O(MAC_EN_O),
    .HOST_IF_EN_O(HOST_IF_EN_O),
    .PHY_TX_EN_O(PHY_TX_EN_O),
    .PHY_RX_EN_O(PHY_RX_EN_O),
    .PHY_ED_EN_O(PHY_ED_EN_O),
    .LINK_PULSE_O(LINK_PULSE_O)
);

// ---- spmc_line_model.sv ----
// Twisted-pair line model: cable energy per port and a link that rises late.
// Assumes the controller clock; a larger LINK_DLY gives a slow partner.
`timescale 1ns/10ps
module spmc_line_model #(
    parameter [7:0] LINK_DLY = 8'h08 // cycles from energy to link
) (
    input wire clk_i, // clock
    input wire rst_i, // reset
    input wire [1:0] plug_i, // cable present
    input wire [1:0] far_i, // far end seeks a link
    output reg [1:0] energy_o, // line energy
    output reg [1:0] link_o // link up
);
    reg [7:0] cnt_q [0:1];
    integer i;
    always @(posedge clk_i) begin
        for (i = 0; i < 2; i = i + 1) begin
            if (rst_i || !plug_i[i]) cnt_q[i] <= 8'h00;
            else if (cnt_q[i] != LINK_DLY) cnt_q[i] <= cnt_q[i] + 8'h01;
            // Unplugged line carries no energy and drops the link at once
            energy_o[i] <= !rst_i && plug_i[i];
            link_o[i] <= !rst_i && plug_i[i] && far_i[i] && cnt_q[i] == LINK_DLY;
        end
    end
endmodule

// ---- spmc_top_tb.sv ----
// Self-checking bench for spmc_top with shortened tick parameters.
// Assumes the checker is bound in and the line model drives energy and link.
`timescale 1ns/10ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_mismatch++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module spmc_top_tb;
    reg CLK_I, RST_I, CYC_I, STB_I, WE_I;
    reg [9:0] ADR_I;
    reg [3:0] SEL_I;
    reg [31:0] DAT_I;
    reg [1:0] AN_EN_I, MGMT_PD_WR_I, MGMT_PD_I, plug, far;
    wire [31:0] DAT_O;
    wire ACK_O, PLL_EN_O, MAC_EN_O, HOST_IF_EN_O;
    wire [1:0] LINK_I, ENERGY_I, PHY_TX_EN_O, PHY_RX_EN_O, PHY_ED_EN_O, LINK_PULSE_O;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n;
    reg [31:0] seed = 32'hae65;
    reg [7:0] rd;
    spmc_top #(.PULSE_PERIOD_CYC(40), .SLEEP_UNIT_CYC(4)) dut (
        .CLK_I(CLK_I),
        .RST_I(RST_I),
        .CYC_I(CYC_I),
        .STB_I(STB_I),
        .WE_I(WE_I),
        .ADR_I(ADR_I),
        .SEL_I(SEL_I),
        .DAT_I(DAT_I),
        .DAT_O(DAT_O),
        .ACK_O(ACK_O),
        .AN_EN_I(AN_EN_I),
        .LINK_I(LINK_I),
        .ENERGY_I(ENERGY_I),
        .MGMT_PD_WR_I(MGMT_PD_WR_I),
        .MGMT_PD_I(MGMT_PD_I),
        .PLL_EN_O(PLL_EN_O),
        .MAC_EN_O(MAC_EN_O),
        .HOST_IF_EN_O(HOST_IF_EN_O),
        .PHY_TX_EN_O(PHY_TX_EN_O),
        .PHY_RX_EN_O(PHY_RX_EN_O),
        .PHY_ED_EN_O(PHY_ED_EN_O),
        .LINK_PULSE_O(LINK_PULSE_O)
    );
    spmc_line_model lm (.clk_i(CLK_I), .rst_i(RST_I), .plug_i(plug), .far_i(far),
        .energy_o(ENERGY_I), .link_o(LINK_I));
    // ********
    // Clock, hang guard, helpers
    // ********
    initial begin
        CLK_I = 1'b0;
        forever #10 CLK_I = ~CLK_I;
    end
    always @(posedge CLK_I) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            finish_test;
        end
    end
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // {pll, mac, host} while awake
    function [2:0] core_exp(input [7:0] g);
        core_exp = (g[1:0] == 2'h2) ? 3'b000 : {~g[2], 2'b11};
    endfunction
    // {tx, rx} with both cables unplugged
    function [3:0] phy_exp(input [1:0] m);
        phy_exp = (m == 2'h2) ? 4'h0 : (m == 2'h3) ? 4'hc : 4'hf;
    endfunction
    task wt(input int c);
        repeat (c) @(posedge CLK_I);
    endtask
    task wb(input reg we, input reg [7:0] idx, input reg [7:0] wd);
        @(posedge CLK_I);
        {CYC_I, STB_I, WE_I, ADR_I, SEL_I, DAT_I} <= {2'b11, we, idx, 2'b00, 4'h1, 24'h0, wd};
        n = 0;
        do begin
            @(posedge CLK_I);
            n++;
        end while (ACK_O !== 1'b1 && n < 40);
        if (n >= 40) n_mismatch++;
        rd = DAT_O[7:0];
        {CYC_I, STB_I} <= 2'b00;
    endtask
    task rchk(input [7:0] idx, input [7:0] e);
        wb(1'b0, idx, 8'h00);
        `CHK(rd, e)
    endtask
    task out_chk(input [2:0] c, input [3:0] p);
        `CHK({PLL_EN_O, MAC_EN_O, HOST_IF_EN_O, PHY_TX_EN_O, PHY_RX_EN_O}, {c, p})
    endtask
    task mgmt(input [1:0] v);
        @(posedge CLK_I);
        MGMT_PD_WR_I <= 2'b10;
        MGMT_PD_I <= v;
        @(posedge CLK_I);
        MGMT_PD_WR_I <= 2'b00;
    endtask
    task wait_pulse;
        n = 0;
        while (LINK_PULSE_O[0] !== 1'b1 && n < 60) begin
            wt(1);
            n++;
        end
    endtask
    task done(input string s);
        $display("test %s done, mismatches %0d", s, n_mismatch);
    endtask
    task finish_test;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ********
    // Main sequence
    // ********
    initial begin
        {CYC_I, STB_I, WE_I, ADR_I, SEL_I, DAT_I} = 0;
        {AN_EN_I, MGMT_PD_WR_I, MGMT_PD_I, plug, far} = {2'b11, 6'h00, 2'b01};
        RST_I = 1'b1;
        wt(16);
        RST_I <= 1'b0;
        wb(1'b1, 8'h77, 8'hff);
        rchk(8'h77, 8'h00);
        rchk(8'h1d, 8'h00);
        rchk(8'h2d, 8'h00);
        rchk(8'hc3, 8'h00);
        rchk(8'hc4, 8'h80);
        rchk(8'hf0, 8'he1);
        out_chk(3'b111, 4'hf);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            wb(1'b1, 8'hc4, seed[7:0]);
            rchk(8'hc4, seed[7:0]);
            wb(1'b1, 8'h2d, seed[15:8]);
            rchk(8'h2d, seed[15:8]);
        end
        wb(1'b1, 8'h2d, 8'h00);
        wb(1'b1, 8'hc4, 8'h10);
        done("registers");
        for (int m = 0; m < 4; m++) begin
            wb(1'b1, 8'hc3, m[7:0]);
            wt(4);
            out_chk(core_exp(m[7:0]), phy_exp(m[1:0]));
            rchk(8'hc3, m[7:0]);
            wb(1'b1, 8'hc3, 8'h00);
            wt(3);
            out_chk(3'b111, 4'hf);
        end
        done("modes");
        wb(1'b1, 8'hc3, 8'h04);
        wt(3);
        out_chk(core_exp(8'h04), 4'hf);
        wb(1'b1, 8'h1d, 8'h08);
        wt(3);
        out_chk(core_exp(8'h04), 4'ha);
        mgmt(2'b10);
        wt(3);
        out_chk(core_exp(8'h04), 4'h0);
        rchk(8'h2d, 8'h08);
        mgmt(2'b00);
        wb(1'b1, 8'h1d, 8'h00);
        wb(1'b1, 8'hc3, 8'h00);
        wt(3);
        out_chk(3'b111, 4'hf);
        done("port power down");
        wb(1'b1, 8'hc3, 8'h03);
        wt(4);
        plug <= 2'b01;
        wt(5);
        out_chk(3'b111, 4'hd);
        plug <= 2'b00;
        AN_EN_I <= 2'b00;
        wt(5);
        out_chk(3'b111, 4'hf);
        AN_EN_I <= 2'b11;
        wb(1'b1, 8'hc3, 8'h00);
        done("saving");
        wb(1'b1, 8'hc4, 8'h02);
        wb(1'b1, 8'hc3, 8'h01);
        wt(6);
        out_chk(3'b111, 4'hf);
        wait_pulse;
        `CHK(LINK_PULSE_O, 2'b11)
        wt(6);
        `CHK(LINK_PULSE_O, 2'b00)
        out_chk(3'b000, 4'h0);
        `CHK(PHY_ED_EN_O, 2'b11)
        wait_pulse;
        `CHK(n, 34)
        rchk(8'hf0, 8'h06);
        wt(7);
        plug <= 2'b01;
        wt(4);
        out_chk(3'b111, 4'hf);
        done("energy detect");
        finish_test;
    end
endmodule
